/* File: common/adc_ctrl_pkg.sv */
// Constants, register map and state types of the converter control block
package adc_ctrl_pkg;

	// Timing
	localparam int CLK_PERIOD_NS      = 100;
	localparam int MIN_CONV_PERIOD_NS = 10000;
	localparam int RATE_CYCLES        =
		(MIN_CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRACK_TICKS        = 3;
	localparam int CONV_TICKS_DEFAULT = 14;
	localparam int RESULT_BITS        = 12;

	// Register indices; byte address is four times the index
	localparam int          ADDR_W       = 10;
	localparam logic [7:0]  IDX_CONFIG   = 8'hbc;
	localparam logic [7:0]  IDX_CONTROL  = 8'he8;
	localparam logic [7:0]  IDX_RES_HI   = 8'hbf;
	localparam logic [7:0]  IDX_RES_LO   = 8'hbe;
	localparam logic [7:0]  IDX_UP_HI    = 8'hc5;
	localparam logic [7:0]  IDX_UP_LO    = 8'hc4;
	localparam logic [7:0]  IDX_LOW_HI   = 8'hc7;
	localparam logic [7:0]  IDX_LOW_LO   = 8'hce;
	localparam logic [7:0]  IDX_IRQ_STAT = 8'hd8;
	localparam logic [7:0]  IDX_IRQ_MASK = 8'hd9;

	// Control register fields
	localparam int BIT_EN    = 7;
	localparam int BIT_TM    = 6;
	localparam int BIT_DONE  = 5;
	localparam int BIT_BUSY  = 4;
	localparam int BIT_SM_HI = 3;
	localparam int BIT_SM_LO = 2;
	localparam int BIT_WIN   = 1;
	localparam int BIT_JUST  = 0;

	// Configuration register: divide select in bits 7..5
	localparam int DIV_LSB = 5;
	localparam int DIV_MSB = 7;

	// Interrupt status and mask bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_WIN  = 1;

	localparam logic [1:0]  SM_SOFTWARE  = 2'h0;
	localparam logic [1:0]  SM_TIMER     = 2'h3;

	// Values after reset
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [7:0]  CONFIG_RESET  = 8'h00;
	localparam logic [15:0] LIMIT_RESET   = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TRACK,
		ST_CONVERT
	} conv_state_t;

	typedef struct packed {
		conv_state_t state;
		logic [7:0]  control;
		logic [7:0]  cfg;
		logic [15:0] upper;
		logic [15:0] lower;
		logic [11:0] result;
		logic [1:0]  irq_status;
		logic [1:0]  irq_mask;
		logic [4:0]  tick_cnt;
		logic [6:0]  rate_cnt;
		logic        pending;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
		logic        converter_on;
		logic        tracking;
		logic        converting;
	} ctrl_state_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic       tick;
	} div_state_t;

endpackage

/* File: core/adc_conversion_control.sv */
// Converter control: APB registers, start and track timing, window detector
// Operation
// [RULE1] Converter clock is pclk divided by 1, 2, 4, 8 or 16 per config field.
// [RULE2] Conversion starts are spaced so the rate never exceeds 100 ksps.
// [RULE3] Start mode 00 starts on software write, 11 on timer overflow; others none.
// [RULE4] Busy reads one during a conversion, zero after it and after reset.
// [RULE5] Writing busy zero does nothing; one starts only in start mode 00.
// [RULE6] When busy falls the done flag sets and may raise an interrupt.
// [RULE7] Done flag stays set until software clears it; hardware never clears.
// [RULE8] Software polls the done flag, not busy, for on-demand completion.
// [RULE9] Enable zero puts the converter in shutdown; one makes it active.
// [RULE10] Track mode zero tracks continuously except while converting.
// [RULE11] Track mode one, start mode 00: software start tracks three ticks.
// [RULE12] Track mode one, start mode 11: timer overflow tracks three ticks.
// [RULE13] Justify bit zero places result right, one places it left.
// [RULE14] Every result is compared against upper and lower limit words.
// [RULE15] Window flag sets on a match, inside or outside per limits.
// [RULE16] Lower above upper means strictly between; else above or below.
// [RULE17] Result load and window check happen as busy falls.
//
// Chosen here: the APB register port.
module adc_conversion_control #(
	parameter int CONV_TICKS = adc_ctrl_pkg::CONV_TICKS_DEFAULT
) (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	output logic                                 irq,
	input  wire logic                            timer_overflow,
	input  wire logic [11:0]                     sample_data,
	output logic                                 converter_on,
	output logic                                 tracking,
	output logic                                 converting
);

	localparam logic [4:0] CONV_LAST  = 5'(CONV_TICKS - 1);
	localparam logic [4:0] TRACK_LAST = 5'(adc_ctrl_pkg::TRACK_TICKS - 1);
	localparam logic [6:0] RATE_LOAD  = 7'(adc_ctrl_pkg::RATE_CYCLES - 1);

	adc_ctrl_pkg::ctrl_state_t s;
	adc_ctrl_pkg::ctrl_state_t next_s;

	logic        tick;
	logic [7:0]  idx;
	logic        setup;
	logic        access;
	logic        wr_access;
	logic        busy;
	logic        conv_start;
	logic        conv_end;
	logic        window_match;
	logic [15:0] new_word;
	logic [15:0] cur_word;
	logic [7:0]  rd_byte;
	logic        rd_hit;
	logic        sw_start;

	conv_clock_divider u_div (
		.pclk          (pclk),
		.presetn       (presetn),
		.divide_select (s.cfg[adc_ctrl_pkg::DIV_MSB:adc_ctrl_pkg::DIV_LSB]),
		.tick          (tick)
	);

	// Result word as it appears across the high and low bytes
	function automatic logic [15:0] justify(input logic [11:0] r,
	                                        input logic        left);
		if (left) begin
			justify = {r, 4'h0}; // [RULE13]
		end else begin
			justify = {4'h0, r}; // [RULE13]
		end
	endfunction

	assign idx       = paddr[adc_ctrl_pkg::ADDR_W-1:2];
	assign setup     = psel && !penable;
	assign access    = psel && penable && s.pready;
	assign wr_access = access && pwrite;
	assign busy      = s.pending || (s.state != adc_ctrl_pkg::ST_IDLE); // [RULE4]
	assign conv_end  = (s.state == adc_ctrl_pkg::ST_CONVERT) && tick &&
	                   (s.tick_cnt == CONV_LAST);
	assign cur_word  = justify(s.result, s.control[adc_ctrl_pkg::BIT_JUST]);
	assign new_word  = justify(sample_data, s.control[adc_ctrl_pkg::BIT_JUST]);

	// The window compares in the same justified form software sees
	always_comb begin
		if (s.lower > s.upper) begin
			window_match = (new_word > s.upper) && (new_word < s.lower); // [RULE16]
		end else begin
			window_match = (new_word > s.upper) || (new_word < s.lower); // [RULE16]
		end
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		unique case (idx)
			adc_ctrl_pkg::IDX_CONFIG:   rd_byte = s.cfg;
			adc_ctrl_pkg::IDX_CONTROL: begin
				rd_byte = s.control;
				rd_byte[adc_ctrl_pkg::BIT_BUSY] = busy; // [RULE4]
			end
			adc_ctrl_pkg::IDX_RES_HI:   rd_byte = cur_word[15:8];
			adc_ctrl_pkg::IDX_RES_LO:   rd_byte = cur_word[7:0];
			adc_ctrl_pkg::IDX_UP_HI:    rd_byte = s.upper[15:8];
			adc_ctrl_pkg::IDX_UP_LO:    rd_byte = s.upper[7:0];
			adc_ctrl_pkg::IDX_LOW_HI:   rd_byte = s.lower[15:8];
			adc_ctrl_pkg::IDX_LOW_LO:   rd_byte = s.lower[7:0];
			adc_ctrl_pkg::IDX_IRQ_STAT: rd_byte = {6'h00, s.irq_status};
			adc_ctrl_pkg::IDX_IRQ_MASK: rd_byte = {6'h00, s.irq_mask};
			default:                    rd_hit  = 1'b0;
		endcase
	end

	always_comb begin
		next_s     = s;
		conv_start = 1'b0;
		sw_start   = 1'b0;

		// APB: one wait-free access phase, read data captured at setup
		next_s.pready  = setup;
		next_s.pslverr = setup && !rd_hit;
		if (setup) begin
			next_s.prdata = {24'h000000, rd_byte};
		end

		if (wr_access) begin
			unique case (idx)
				adc_ctrl_pkg::IDX_CONFIG:   next_s.cfg = pwdata[7:0];
				adc_ctrl_pkg::IDX_CONTROL: begin
					// Busy is not stored; a one is a start request
					next_s.control = pwdata[7:0];
					next_s.control[adc_ctrl_pkg::BIT_BUSY] = 1'b0;
					sw_start = pwdata[adc_ctrl_pkg::BIT_BUSY] &&
					           pwdata[adc_ctrl_pkg::BIT_EN] &&
					           (pwdata[3:2] == adc_ctrl_pkg::SM_SOFTWARE); // [RULE5]
				end
				adc_ctrl_pkg::IDX_UP_HI:    next_s.upper[15:8] = pwdata[7:0];
				adc_ctrl_pkg::IDX_UP_LO:    next_s.upper[7:0]  = pwdata[7:0];
				adc_ctrl_pkg::IDX_LOW_HI:   next_s.lower[15:8] = pwdata[7:0];
				adc_ctrl_pkg::IDX_LOW_LO:   next_s.lower[7:0]  = pwdata[7:0];
				adc_ctrl_pkg::IDX_IRQ_STAT:
					next_s.irq_status = s.irq_status & ~pwdata[1:0];
				adc_ctrl_pkg::IDX_IRQ_MASK: next_s.irq_mask = pwdata[1:0];
				default: ;
			endcase
		end

		// A start asked while busy is dropped, as the bit already reads one
		if (sw_start && !busy) begin
			next_s.pending = 1'b1; // [RULE3]
		end

		if (s.rate_cnt != 7'h00) begin
			next_s.rate_cnt = s.rate_cnt - 7'h01;
		end

		unique case (s.state)
			adc_ctrl_pkg::ST_IDLE: begin
				// Pending software starts wait out the rate limit; overflows
				// arriving too early are dropped since they are periodic
				if (s.rate_cnt == 7'h00 && s.control[adc_ctrl_pkg::BIT_EN]) begin // [RULE2]
					if (s.pending) begin
						conv_start = 1'b1;
					end else if (timer_overflow &&
					             s.control[3:2] == adc_ctrl_pkg::SM_TIMER) begin // [RULE3]
						conv_start = 1'b1;
					end
				end
				if (conv_start) begin
					next_s.pending  = 1'b0;
					next_s.rate_cnt = RATE_LOAD; // [RULE2]
					next_s.tick_cnt = 5'h00;
					if (s.control[adc_ctrl_pkg::BIT_TM]) begin
						next_s.state = adc_ctrl_pkg::ST_TRACK; // [RULE11] [RULE12]
					end else begin
						next_s.state = adc_ctrl_pkg::ST_CONVERT; // [RULE10]
					end
				end
			end
			adc_ctrl_pkg::ST_TRACK: begin
				if (tick) begin
					if (s.tick_cnt == TRACK_LAST) begin // [RULE11] [RULE12]
						next_s.tick_cnt = 5'h00;
						next_s.state    = adc_ctrl_pkg::ST_CONVERT;
					end else begin
						next_s.tick_cnt = s.tick_cnt + 5'h01;
					end
				end
			end
			adc_ctrl_pkg::ST_CONVERT: begin
				if (conv_end) begin
					// Load, compare and flag in the cycle busy falls
					next_s.state  = adc_ctrl_pkg::ST_IDLE; // [RULE4]
					next_s.result = sample_data; // [RULE17]
					next_s.control[adc_ctrl_pkg::BIT_DONE] = 1'b1; // [RULE6] [RULE7]
					next_s.irq_status[adc_ctrl_pkg::IRQ_DONE] = 1'b1; // [RULE6]
					if (window_match) begin
						next_s.control[adc_ctrl_pkg::BIT_WIN] = 1'b1; // [RULE14] [RULE15]
						next_s.irq_status[adc_ctrl_pkg::IRQ_WIN] = 1'b1; // [RULE15]
					end
				end else if (tick) begin
					next_s.tick_cnt = s.tick_cnt + 5'h01;
				end
			end
			default: next_s.state = adc_ctrl_pkg::ST_IDLE;
		endcase

		// Outputs follow the next state so the pins come from flip-flops
		next_s.irq = |(next_s.irq_status & next_s.irq_mask);
		next_s.converter_on = next_s.control[adc_ctrl_pkg::BIT_EN]; // [RULE9]
		next_s.converting   = next_s.state == adc_ctrl_pkg::ST_CONVERT;
		if (!next_s.control[adc_ctrl_pkg::BIT_EN]) begin
			next_s.tracking = 1'b0; // [RULE9]
		end else if (next_s.control[adc_ctrl_pkg::BIT_TM]) begin
			next_s.tracking = next_s.state == adc_ctrl_pkg::ST_TRACK; // [RULE11]
		end else begin
			next_s.tracking = next_s.state != adc_ctrl_pkg::ST_CONVERT; // [RULE10]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s          <= '0;
			s.state    <= adc_ctrl_pkg::ST_IDLE;
			s.control  <= adc_ctrl_pkg::CONTROL_RESET;
			s.cfg      <= adc_ctrl_pkg::CONFIG_RESET;
			s.upper    <= adc_ctrl_pkg::LIMIT_RESET;
			s.lower    <= adc_ctrl_pkg::LIMIT_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign prdata       = s.prdata;
	assign pready       = s.pready;
	assign pslverr      = s.pslverr;
	assign irq          = s.irq;
	assign converter_on = s.converter_on;
	assign tracking     = s.tracking;
	assign converting   = s.converting;

	property p_done_on_fall;
		@(posedge pclk) disable iff (!presetn)
		$fell(busy) |-> s.control[adc_ctrl_pkg::BIT_DONE] &&
		                s.irq_status[adc_ctrl_pkg::IRQ_DONE];
	endproperty
	a_done_on_fall: assert property (p_done_on_fall) // [RULE6]
		else $error("done flag not set as busy fell");

	property p_done_sticky;
		@(posedge pclk) disable iff (!presetn)
		s.control[adc_ctrl_pkg::BIT_DONE] &&
		!(wr_access && idx == adc_ctrl_pkg::IDX_CONTROL)
		|=> s.control[adc_ctrl_pkg::BIT_DONE];
	endproperty
	a_done_sticky: assert property (p_done_sticky) // [RULE7]
		else $error("done flag cleared without a software write");

	property p_rate_spacing;
		@(posedge pclk) disable iff (!presetn)
		conv_start |=> !conv_start [*8] ##0 (s.rate_cnt == RATE_LOAD - 7'h07);
	endproperty
	a_rate_spacing: assert property (p_rate_spacing) // [RULE2]
		else $error("conversion starts closer than the rate limit");

	property p_start_mode;
		@(posedge pclk) disable iff (!presetn)
		conv_start && !s.pending |-> timer_overflow &&
		s.control[3:2] == adc_ctrl_pkg::SM_TIMER;
	endproperty
	a_start_mode: assert property (p_start_mode) // [RULE3]
		else $error("hardware start outside timer start mode");

	property p_zero_write;
		@(posedge pclk) disable iff (!presetn)
		wr_access && idx == adc_ctrl_pkg::IDX_CONTROL && !busy &&
		!pwdata[adc_ctrl_pkg::BIT_BUSY] && !timer_overflow |=> !busy;
	endproperty
	a_zero_write: assert property (p_zero_write) // [RULE5]
		else $error("writing busy zero started a conversion");

	property p_track_three;
		@(posedge pclk) disable iff (!presetn)
		s.state == adc_ctrl_pkg::ST_TRACK && tick |=>
		(s.state == adc_ctrl_pkg::ST_CONVERT) ==
		($past(s.tick_cnt) == TRACK_LAST);
	endproperty
	a_track_three: assert property (p_track_three) // [RULE11] [RULE12]
		else $error("tracking did not last three converter ticks");

	property p_shutdown;
		@(posedge pclk) disable iff (!presetn)
		!s.control[adc_ctrl_pkg::BIT_EN] |-> !converter_on && !tracking;
	endproperty
	a_shutdown: assert property (p_shutdown) // [RULE9]
		else $error("converter active while disabled");

	property p_continuous_track;
		@(posedge pclk) disable iff (!presetn)
		s.control[adc_ctrl_pkg::BIT_EN] && !s.control[adc_ctrl_pkg::BIT_TM]
		|-> tracking == !converting;
	endproperty
	a_continuous_track: assert property (p_continuous_track) // [RULE10]
		else $error("continuous tracking wrong around conversion");

	property p_result_load;
		@(posedge pclk) disable iff (!presetn)
		conv_end |=> s.result == $past(sample_data) &&
		(s.control[adc_ctrl_pkg::BIT_WIN] || !$past(window_match));
	endproperty
	a_result_load: assert property (p_result_load) // [RULE17] [RULE15]
		else $error("result or window flag not updated at end");

endmodule

/* File: core/conv_clock_divider.sv */
// Converter clock divider giving a one-cycle tick at 1/1 to 1/16 of pclk
module conv_clock_divider (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [2:0] divide_select,
	output logic            tick
);

	adc_ctrl_pkg::div_state_t s;
	adc_ctrl_pkg::div_state_t next_s;
	logic [3:0]               ratio_m1;

	always_comb begin
		unique case (divide_select)
			3'h0:    ratio_m1 = 4'h0;
			3'h1:    ratio_m1 = 4'h1;
			3'h2:    ratio_m1 = 4'h3;
			3'h3:    ratio_m1 = 4'h7;
			default: ratio_m1 = 4'hf;
		endcase
	end

	// Compare with >= so a smaller ratio chosen mid-count wraps at once
	always_comb begin
		next_s = s;
		if (s.cnt >= ratio_m1) begin // [RULE1]
			next_s.cnt  = 4'h0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt  = s.cnt + 4'h1;
			next_s.tick = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule

/* File: tb/adc_conversion_control_bench.sv */
// Self-checking bench for the converter control block
module adc_conversion_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIMIT   = 20000;
	localparam int DIV4_HI = adc_ctrl_pkg::TRACK_TICKS * 4;
	localparam int DIV4_LO = DIV4_HI - 3;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        fire;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        err;
	logic        timer_overflow;
	logic        converter_on;
	logic        tracking;
	logic        converting;
	logic [9:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [11:0] value;
	logic [11:0] sample_data;
	int          n_fail;
	int          total_checks;
	int          cycles;

	int          n;

	adc_conversion_control adc_conversion_control_i (
		.pclk           (pclk),
		.presetn        (presetn),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.paddr          (paddr),
		.pwdata         (pwdata),
		.prdata         (prdata),
		.pready         (pready),
		.pslverr        (pslverr),
		.irq            (irq),
		.timer_overflow (timer_overflow),
		.sample_data    (sample_data),
		.converter_on   (converter_on),
		.tracking       (tracking),
		.converting     (converting)
	);

	adc_partner adc_partner_i (
		.pclk           (pclk),
		.presetn        (presetn),
		.fire           (fire),
		.value          (value),
		.timer_overflow (timer_overflow),
		.sample_data    (sample_data)
	);

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always_ff @(posedge pclk) cycles <= cycles + 1;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("Checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] idx,
	                   input logic [31:0] data);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready && cycles < LIMIT);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cycles_wait(input int k);
		repeat (k) @(posedge pclk);
	endtask

	task automatic wait_level(input logic lvl, input logic trk);
		do @(posedge pclk);
		while ((trk ? tracking : converting) !== lvl && cycles < LIMIT);
	endtask

	task automatic poll_done;
		do apb(1'b0, adc_ctrl_pkg::IDX_CONTROL, 32'h0);
		while (!rd[adc_ctrl_pkg::BIT_DONE] && cycles < LIMIT);
	endtask

	task automatic track_len(output int len);
		wait_level(1'b1, 1'b1);
		len = 0;
		while (tracking && cycles < LIMIT) begin
			len++;
			@(posedge pclk);
		end
	endtask

	task automatic do_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		fire    <= 1'b0;
		value   <= 12'h000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask

	task automatic reset_values;
		do_reset();
		check(32'({converter_on, tracking, converting, irq}), 32'h0);
		apb(1'b0, adc_ctrl_pkg::IDX_CONTROL, 32'h0);
		check(rd, 32'(adc_ctrl_pkg::CONTROL_RESET));
		apb(1'b0, adc_ctrl_pkg::IDX_CONFIG, 32'h0);
		check(rd, 32'(adc_ctrl_pkg::CONFIG_RESET));
		apb(1'b0, adc_ctrl_pkg::IDX_UP_HI, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		check(32'({err, rd[7:0]}), 32'h100);
	endtask

	task automatic sw_conversion;
		value <= 12'habc;
		apb(1'b1, adc_ctrl_pkg::IDX_CONFIG, 32'h00);
		apb(1'b1, adc_ctrl_pkg::IDX_IRQ_MASK, 32'h03);
		apb(1'b1, adc_ctrl_pkg::IDX_UP_HI, 32'h01);
		apb(1'b1, adc_ctrl_pkg::IDX_CONTROL, 32'h90);
		apb(1'b0, adc_ctrl_pkg::IDX_CONTROL, 32'h0);
		check(32'(rd[adc_ctrl_pkg::BIT_BUSY]), 32'h1);
		poll_done();
		check(rd, 32'ha2);
		apb(1'b0, adc_ctrl_pkg::IDX_RES_HI, 32'h0);
		check(rd, 32'h0a);
		apb(1'b0, adc_ctrl_pkg::IDX_RES_LO, 32'h0);
		check(rd, 32'hbc);
		check(32'(irq), 32'h1);
		apb(1'b0, adc_ctrl_pkg::IDX_IRQ_STAT, 32'h0);
		check(rd, 32'h3);
	endtask

	task automatic flags_sticky;
		cycles_wait(20);
		apb(1'b0, adc_ctrl_pkg::IDX_CONTROL, 32'h0);
		check(32'(rd[adc_ctrl_pkg::BIT_DONE]), 32'h1);
		apb(1'b1, adc_ctrl_pkg::IDX_IRQ_STAT, 32'h1);
		apb(1'b0, adc_ctrl_pkg::IDX_IRQ_STAT, 32'h0);
		check(rd, 32'h2);
		apb(1'b1, adc_ctrl_pkg::IDX_IRQ_STAT, 32'h2);
		cycles_wait(1);
		check(32'(irq), 32'h0);
	endtask

	task automatic start_refused;
		apb(1'b1, adc_ctrl_pkg::IDX_CONTROL, 32'h80);
		cycles_wait(5);
		check(32'(converting), 32'h0);
		apb(1'b0, adc_ctrl_pkg::IDX_CONTROL, 32'h0);
		check(rd, 32'h80);
		apb(1'b1, adc_ctrl_pkg::IDX_CONTROL, 32'h9c);
		cycles_wait(5);
		check(32'(converting), 32'h0);
		apb(1'b0, adc_ctrl_pkg::IDX_CONTROL, 32'h0);
		check(rd, 32'h8c);
	endtask

	task automatic timer_window;
		value <= 12'h123;
		apb(1'b1, adc_ctrl_pkg::IDX_UP_HI, 32'h10);
		apb(1'b1, adc_ctrl_pkg::IDX_LOW_HI, 32'h20);
		apb(1'b1, adc_ctrl_pkg::IDX_CONTROL, 32'hcd);
		cycles_wait(110);
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		track_len(n);
		check(32'(n), 32'(adc_ctrl_pkg::TRACK_TICKS));
		wait_level(1'b0, 1'b0);
		apb(1'b0, adc_ctrl_pkg::IDX_CONTROL, 32'h0);
		check(rd, 32'hef);
		apb(1'b0, adc_ctrl_pkg::IDX_RES_HI, 32'h0);
		check(rd, 32'h12);
		apb(1'b0, adc_ctrl_pkg::IDX_RES_LO, 32'h0);
		check(rd, 32'h30);
	endtask

	task automatic enable_track;
		apb(1'b1, adc_ctrl_pkg::IDX_CONTROL, 32'h00);
		cycles_wait(1);
		check(32'({converter_on, tracking}), 32'h0);
		apb(1'b1, adc_ctrl_pkg::IDX_CONTROL, 32'h80);
		cycles_wait(1);
		check(32'({converter_on, tracking}), 32'h3);
	endtask

	task automatic divided_track;
		apb(1'b1, adc_ctrl_pkg::IDX_CONFIG, 32'h40);
		apb(1'b1, adc_ctrl_pkg::IDX_CONTROL, 32'hd0);
		track_len(n);
		check(32'(n >= DIV4_LO && n <= DIV4_HI), 32'h1);
		poll_done();
	endtask

	task automatic rate_limit;
		int t0;
		apb(1'b1, adc_ctrl_pkg::IDX_CONFIG, 32'h00);
		apb(1'b1, adc_ctrl_pkg::IDX_CONTROL, 32'h90);
		wait_level(1'b1, 1'b0);
		t0 = cycles;
		wait_level(1'b0, 1'b0);
		apb(1'b1, adc_ctrl_pkg::IDX_CONTROL, 32'h90);
		wait_level(1'b1, 1'b0);
		check(32'(cycles - t0), 32'(adc_ctrl_pkg::RATE_CYCLES));
	endtask

	// A hang anywhere still ends in the closing report
	initial begin
		wait (cycles >= LIMIT);
		n_fail++;
		summarize();
	end

	initial begin
		presetn <= 1'b0;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= 10'h000;
		pwdata  <= 32'h0;
		fire    <= 1'b0;
		value   <= 12'h000;
		reset_values();
		sw_conversion();
		flags_sticky();
		start_refused();
		timer_window();
		enable_track();
		divided_track();
		rate_limit();
		reset_values();
		summarize();
	end
endmodule

/* File: tb/adc_partner.sv */
// Timer overflow and converter data source facing the control block
module adc_partner (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        fire,
	input  wire logic [11:0] value,
	output logic             timer_overflow,
	output logic [11:0]      sample_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// Overflow is one cycle wide, as a free-running timer gives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_overflow <= 1'b0;
			sample_data    <= 12'h000;
		end else begin
			timer_overflow <= fire & ~timer_overflow;
			sample_data    <= value;
		end
	end
endmodule
